// File: logic/interrupt_and_reset_status.sv
// Purpose: interrupt enables, sticky flags, core request and reset-cause status
// Assumes: rst_i is the power-on reset; pins arrive asynchronously
// Notes:   register access answers one cycle after the strobe on reg_rdata
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module interrupt_and_reset_status #(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic   mclk_i,
  input  wire logic   rst_i,
  irq_link_if.dev     link,
  output logic        brownout_sw_enable_o
);
  localparam int unsigned PW = irq_pkg::PORT_W;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]    intctl_reg;
  logic [7:0]    intctl_next;
  logic [7:0]    pie_reg;
  logic [7:0]    pie_next;
  logic [7:0]    pir_reg;
  logic [7:0]    pir_next;
  logic [PW-1:0] pcmask_reg;
  logic [PW-1:0] pin_hit_reg;
  logic [PW-1:0] pin_hit_next;
  logic          poweron_reg;
  logic          brownout_reg;
  logic          brownout_next;
  logic          bo_sw_en_reg;
  logic [7:0]    rdata_reg;
  logic [7:0]    rd_word;
  logic [7:0]    impl_mask;
  logic [8:0]    pins;
  logic [8:0]    pin_change;
  logic [8:0]    pin_rise;
  logic [8:0]    pin_fall;
  logic          wr_intctl;
  logic          wr_pie;
  logic          wr_pir;
  logic          wr_rstat;
  logic          wr_pcmask;
  logic          ev_t0;
  logic          ev_ext;
  logic          ev_pc;
  logic [7:0]    ev_periph;
  logic          cc_hit;
  logic          core_req;
  logic          periph_req;

  // ---------------------------------------------------------------
  // pin synchronising and edge finding
  // ---------------------------------------------------------------
  assign pins = {link.comparator_out, link.ext_irq_pin, link.io_port};

  edge_watch #(
    .W (9)
  ) u_edges (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .pin_i    (pins),
    .change_o (pin_change),
    .rise_o   (pin_rise),
    .fall_o   (pin_fall)
  );

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
    hit = (idx == want);
  endfunction

  assign wr_intctl = link.reg_wr && hit(link.reg_idx, irq_pkg::IDX_INTCTL);
  assign wr_pie    = link.reg_wr && hit(link.reg_idx, irq_pkg::IDX_PIE);
  assign wr_pir    = link.reg_wr && hit(link.reg_idx, irq_pkg::IDX_PIR);
  assign wr_rstat  = link.reg_wr && hit(link.reg_idx, irq_pkg::IDX_RSTAT);
  assign wr_pcmask = link.reg_wr && hit(link.reg_idx, irq_pkg::IDX_PCMASK);

  // implemented peripheral bits for this variant
  assign impl_mask = REDUCED ? irq_pkg::PERIPH_SMALL : irq_pkg::PERIPH_FULL;

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  // timer0 count lives in the core; only its rollover pulse comes here
  assign ev_t0  = link.timer0_ovf;
  assign ev_ext = link.ext_edge_select ? pin_rise[PW] : pin_fall[PW];
  assign ev_pc  = |pin_change[PW-1:0];
  assign cc_hit = ((link.capcomp_mode == irq_pkg::CC_CAPTURE) && link.capture_evt)
               || ((link.capcomp_mode == irq_pkg::CC_COMPARE) && link.compare_evt);

  // peripheral events placed at their flag positions
  always_comb begin
    ev_periph                     = 8'h00;
    ev_periph[irq_pkg::B_CONV]    = link.converter_done;
    ev_periph[irq_pkg::B_CAPCOMP] = cc_hit;
    ev_periph[irq_pkg::B_CMP2]    = pin_change[PW+2];
    ev_periph[irq_pkg::B_CMP1]    = pin_change[PW+1];
    ev_periph[irq_pkg::B_TMR2]    = link.timer2_match;
    ev_periph[irq_pkg::B_TMR1]    = link.timer1_ovf;
  end

  // ---------------------------------------------------------------
  // next values: software write, then events win: flag events over clears, the brownout event over sets
  // ---------------------------------------------------------------
  always_comb begin
    intctl_next = wr_intctl ? link.reg_wdata : intctl_reg;
    intctl_next[irq_pkg::B_T0_FLAG]  = intctl_next[irq_pkg::B_T0_FLAG] | ev_t0;
    intctl_next[irq_pkg::B_EXT_FLAG] = intctl_next[irq_pkg::B_EXT_FLAG] | ev_ext;
    intctl_next[irq_pkg::B_PC_FLAG]  = intctl_next[irq_pkg::B_PC_FLAG] | ev_pc;
    pie_next = (wr_pie ? link.reg_wdata : pie_reg) & impl_mask;
    pir_next = ((wr_pir ? link.reg_wdata : pir_reg) | ev_periph) & impl_mask;
    // per-pin history follows the port change flag
    pin_hit_next = intctl_next[irq_pkg::B_PC_FLAG] ? pin_hit_reg : '0;
    pin_hit_next = pin_hit_next | pin_change[PW-1:0];
    brownout_next = wr_rstat ? link.reg_wdata[irq_pkg::B_BROWNOUT] : brownout_reg;
    brownout_next = brownout_next & ~link.brownout_evt;
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      intctl_reg  <= irq_pkg::INTCTL_RST;
      pie_reg     <= irq_pkg::PIE_RST;
      pir_reg     <= irq_pkg::PIR_RST;
      pin_hit_reg <= irq_pkg::PCMASK_RST;
      pcmask_reg  <= irq_pkg::PCMASK_RST;
      poweron_reg <= irq_pkg::POWERON_RST;
      brownout_reg <= irq_pkg::BROWNOUT_RST;
      bo_sw_en_reg <= irq_pkg::BO_SW_EN_RST;
    end else begin
      intctl_reg  <= intctl_next;
      pie_reg     <= pie_next;
      pir_reg     <= pir_next;
      pin_hit_reg <= pin_hit_next;
      brownout_reg <= brownout_next;
      if (wr_pcmask) begin
        pcmask_reg <= link.reg_wdata[PW-1:0];
      end
      if (wr_rstat) begin
        poweron_reg  <= link.reg_wdata[irq_pkg::B_POWERON];
        bo_sw_en_reg <= link.reg_wdata[irq_pkg::B_BO_SW_EN];
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 8'h00;
    case (link.reg_idx)
      irq_pkg::IDX_INTCTL: rd_word = intctl_reg;
      irq_pkg::IDX_PIE:    rd_word = pie_reg & impl_mask;
      irq_pkg::IDX_PIR:    rd_word = pir_reg & impl_mask;
      irq_pkg::IDX_RSTAT: begin
        rd_word[irq_pkg::B_POWERON]  = poweron_reg;
        rd_word[irq_pkg::B_BROWNOUT] = brownout_reg & bo_sw_en_reg;
      end
      irq_pkg::IDX_PCMASK: rd_word = {2'b00, pcmask_reg};
      default:             rd_word = 8'h00;
    endcase
  end

  // read data is held from the strobe edge until the next read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (link.reg_rd) begin
      rdata_reg <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // request to the core
  // ---------------------------------------------------------------
  assign core_req = (intctl_reg[irq_pkg::B_T0_FLAG] & intctl_reg[irq_pkg::B_T0_EN])
                  | (intctl_reg[irq_pkg::B_EXT_FLAG] & intctl_reg[irq_pkg::B_EXT_EN])
                  | (intctl_reg[irq_pkg::B_PC_FLAG] & intctl_reg[irq_pkg::B_PC_EN]
                     & |(pin_hit_reg & pcmask_reg));
  assign periph_req = intctl_reg[irq_pkg::B_PGROUP] & |(pir_reg & pie_reg & impl_mask);

  assign link.irq_req  = intctl_reg[irq_pkg::B_GLOBAL] & (core_req | periph_req);
  assign link.reg_rdata = rdata_reg;
  assign brownout_sw_enable_o = bo_sw_en_reg;
endmodule
`default_nettype wire

// File: logic/irq_pkg.sv
// Purpose: shared constants for the interrupt and reset status block and its core end
// Assumes: 8-bit registers reached by a 3-bit register index
// Notes:   byte address on the software bus is four times the register index
package irq_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam int unsigned IDX_W         = 3;
  localparam int unsigned DATA_W        = 8;
  localparam logic [2:0]  IDX_INTCTL    = 3'h0;
  localparam logic [2:0]  IDX_PIE       = 3'h1;
  localparam logic [2:0]  IDX_PIR       = 3'h2;
  localparam logic [2:0]  IDX_RSTAT     = 3'h3;
  localparam logic [2:0]  IDX_PCMASK    = 3'h4;
  localparam logic [2:0]  IDX_LINKSTAT  = 3'h5;

  // ---------------------------------------------------------------
  // interrupt_control fields
  // ---------------------------------------------------------------
  localparam int unsigned B_GLOBAL      = 7;
  localparam int unsigned B_PGROUP      = 6;
  localparam int unsigned B_T0_EN       = 5;
  localparam int unsigned B_EXT_EN      = 4;
  localparam int unsigned B_PC_EN       = 3;
  localparam int unsigned B_T0_FLAG     = 2;
  localparam int unsigned B_EXT_FLAG    = 1;
  localparam int unsigned B_PC_FLAG     = 0;

  // ---------------------------------------------------------------
  // peripheral enable and flag fields
  // ---------------------------------------------------------------
  localparam int unsigned B_CONV        = 6;
  localparam int unsigned B_CAPCOMP     = 5;
  localparam int unsigned B_CMP2        = 4;
  localparam int unsigned B_CMP1        = 3;
  localparam int unsigned B_TMR2        = 1;
  localparam int unsigned B_TMR1        = 0;
  localparam logic [7:0]  PERIPH_FULL   = 8'h7B;
  localparam logic [7:0]  PERIPH_SMALL  = 8'h19;

  // ---------------------------------------------------------------
  // reset_cause_status fields
  // ---------------------------------------------------------------
  localparam int unsigned B_POWERON     = 1;
  localparam int unsigned B_BROWNOUT    = 0;
  localparam int unsigned B_BO_SW_EN    = 2;
  localparam int unsigned PORT_W        = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  INTCTL_RST    = 8'h00;
  localparam logic [7:0]  PIE_RST       = 8'h00;
  localparam logic [7:0]  PIR_RST       = 8'h00;
  localparam logic [5:0]  PCMASK_RST    = 6'h00;
  localparam logic        POWERON_RST   = 1'b0;
  localparam logic        BROWNOUT_RST  = 1'b0;
  localparam logic        BO_SW_EN_RST  = 1'b0;

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_PWM} capcomp_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FETCH, ST_DONE} host_state_e;

endpackage

// File: logic/irq_link_if.sv
// Purpose: link between the interrupt block and the processor core side
// Assumes: both ends run on the same clock
// Notes:   pin levels cross unsynchronised; the block synchronises them
`timescale 1ns/100ps
`default_nettype none
interface irq_link_if;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [2:0]              reg_idx;
  logic [7:0]              reg_wdata;
  logic [7:0]              reg_rdata;
  logic                    irq_req;
  logic                    timer0_ovf;
  logic                    ext_irq_pin;
  logic                    ext_edge_select;
  logic [5:0]              io_port;
  logic [1:0]              comparator_out;
  logic                    converter_done;
  logic                    capture_evt;
  logic                    compare_evt;
  irq_pkg::capcomp_mode_e  capcomp_mode;
  logic                    timer2_match;
  logic                    timer1_ovf;
  logic                    brownout_evt;

  modport dev (
    input  reg_wr, reg_rd, reg_idx, reg_wdata, timer0_ovf, ext_irq_pin, ext_edge_select, io_port,
           comparator_out, converter_done, capture_evt, compare_evt, capcomp_mode, timer2_match,
           timer1_ovf, brownout_evt,
    output reg_rdata, irq_req
  );
  modport core (
    output reg_wr, reg_rd, reg_idx, reg_wdata, timer0_ovf, ext_irq_pin, ext_edge_select, io_port,
           comparator_out, converter_done, capture_evt, compare_evt, capcomp_mode, timer2_match,
           timer1_ovf, brownout_evt,
    input  reg_rdata, irq_req
  );
endinterface
`default_nettype wire

// File: logic/edge_watch.sv
// Purpose: synchronise pin levels and report change, rise and fall per bit
// Assumes: inputs are asynchronous to mclk_i
// Notes:   outputs are one-cycle pulses, one to two cycles after the pin moves
`timescale 1ns/100ps
`default_nettype none
module edge_watch #(
  parameter int unsigned W = 9
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic [W-1:0]  pin_i,
  output logic      [W-1:0]  change_o,
  output logic      [W-1:0]  rise_o,
  output logic      [W-1:0]  fall_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // ---------------------------------------------------------------
  // two-stage synchroniser and history
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges seen between the synced and the history stage
  assign change_o = sync_reg ^ last_reg;
  assign rise_o   = sync_reg & ~last_reg;
  assign fall_o   = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// File: logic/core_end.sv
// Purpose: core-side end: software bus bridge to the block plus event forwarding
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, word aligned
// Notes:   every access holds waitrequest for three cycles
`timescale 1ns/100ps
`default_nettype none
module core_end (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  irq_link_if.core                     link,
  input  wire logic [4:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire logic                    timer0_ovf_i,
  input  wire logic                    ext_irq_pin_i,
  input  wire logic                    ext_edge_select_i,
  input  wire logic [5:0]              io_port_i,
  input  wire logic [1:0]              comparator_out_i,
  input  wire logic                    converter_done_i,
  input  wire logic                    capture_evt_i,
  input  wire logic                    compare_evt_i,
  input  wire irq_pkg::capcomp_mode_e  capcomp_mode_i,
  input  wire logic                    timer2_match_i,
  input  wire logic                    timer1_ovf_i,
  input  wire logic                    brownout_evt_i,
  output logic                         irq_o
);
  irq_pkg::host_state_e state_reg;
  irq_pkg::host_state_e state_next;
  logic [31:0] readdata_reg;
  logic        irq_reg;
  logic [2:0]  idx;
  logic        to_block;
  logic        busy;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign idx      = avs_address_i[4:2];
  assign to_block = (idx <= irq_pkg::IDX_PCMASK);
  assign busy     = avs_read_i | avs_write_i;

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irq_pkg::ST_IDLE:  state_next = busy ? irq_pkg::ST_ISSUE : irq_pkg::ST_IDLE;
      irq_pkg::ST_ISSUE: state_next = irq_pkg::ST_FETCH;
      irq_pkg::ST_FETCH: state_next = irq_pkg::ST_DONE;
      irq_pkg::ST_DONE:  state_next = irq_pkg::ST_IDLE;
      default:           state_next = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= irq_pkg::ST_IDLE;
      readdata_reg <= 32'h0000_0000;
      irq_reg      <= 1'b0;
    end else begin
      state_reg <= state_next;
      irq_reg   <= link.irq_req;
      if (state_reg == irq_pkg::ST_FETCH) begin
        // unmapped words read as zero
        readdata_reg <= to_block ? {24'h00_0000, link.reg_rdata}
                      : (idx == irq_pkg::IDX_LINKSTAT) ? {31'h0000_0000, irq_reg} : 32'h0000_0000;
      end
    end
  end

  // read strobe at issue; write strobe in the accepting cycle, so it lands with waitrequest low
  assign link.reg_wr    = (state_reg == irq_pkg::ST_DONE) && avs_write_i && to_block;
  assign link.reg_rd    = (state_reg == irq_pkg::ST_ISSUE) && avs_read_i && to_block;
  assign link.reg_idx   = idx;
  assign link.reg_wdata = avs_writedata_i[7:0];

  assign avs_waitrequest_o = busy && (state_reg != irq_pkg::ST_DONE);
  assign avs_readdata_o    = readdata_reg;
  assign irq_o             = irq_reg;

  // ---------------------------------------------------------------
  // event and pin forwarding
  // ---------------------------------------------------------------
  assign link.timer0_ovf      = timer0_ovf_i;
  assign link.ext_irq_pin     = ext_irq_pin_i;
  assign link.ext_edge_select = ext_edge_select_i;
  assign link.io_port         = io_port_i;
  assign link.comparator_out  = comparator_out_i;
  assign link.converter_done  = converter_done_i;
  assign link.capture_evt     = capture_evt_i;
  assign link.compare_evt     = compare_evt_i;
  assign link.capcomp_mode    = capcomp_mode_i;
  assign link.timer2_match    = timer2_match_i;
  assign link.timer1_ovf      = timer1_ovf_i;
  assign link.brownout_evt    = brownout_evt_i;
endmodule
`default_nettype wire

// File: bench/irq_link_chk.sv
// Purpose: assertions on the link between the interrupt block and the core end
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   enable bits are shadowed from writes seen on the link
`timescale 1ns/100ps
`default_nettype none
module irq_link_chk (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        irq_req,
  input  wire logic        timer0_ovf,
  input  wire logic        timer1_ovf,
  input  wire logic        ext_irq_pin,
  input  wire logic        ext_edge_select
);
  logic [7:0]  ctl_reg;
  logic [7:0]  pie_reg;
  logic        boen_reg;
  // access decode
  wire logic   wr_ctl = reg_wr && (reg_idx == irq_pkg::IDX_INTCTL);
  wire logic   wr_pie = reg_wr && (reg_idx == irq_pkg::IDX_PIE);
  wire logic   wr_rst = reg_wr && (reg_idx == irq_pkg::IDX_RSTAT);
  wire logic   rd_rst = reg_rd && (reg_idx == irq_pkg::IDX_RSTAT);
  wire logic   rd_per = reg_rd && (reg_idx inside {irq_pkg::IDX_PIE, irq_pkg::IDX_PIR});
  // shadow of last written enables
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg  <= 8'h00;
      pie_reg  <= 8'h00;
      boen_reg <= 1'b0;
    end else begin
      if (wr_ctl) ctl_reg <= reg_wdata;
      if (wr_pie) pie_reg <= reg_wdata;
      if (wr_rst) boen_reg <= reg_wdata[irq_pkg::B_BO_SW_EN];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // chosen pin edge with its request enabled
  sequence s_ext_edge;
    ((ext_edge_select && $rose(ext_irq_pin)) || (!ext_edge_select && $fell(ext_irq_pin)))
      && ctl_reg[7] && ctl_reg[4];
  endsequence
  sequence s_req_soon;
    ##[1:4] irq_req;
  endsequence
  property p_gate; irq_req |-> ctl_reg[7]; endproperty
  property p_t0; timer0_ovf && ctl_reg[7] && ctl_reg[5] && !reg_wr |=> irq_req; endproperty
  property p_t1; timer1_ovf && (ctl_reg[7:6] == 2'b11) && pie_reg[0] && !reg_wr |=> irq_req; endproperty
  property p_hold; irq_req && !reg_wr |=> irq_req; endproperty
  property p_per; rd_per |=> (reg_rdata[7] == 1'b0) && (reg_rdata[2] == 1'b0); endproperty
  property p_rst; rd_rst |=> (reg_rdata[7:2] == 6'h00); endproperty
  property p_bo; rd_rst && !boen_reg |=> (reg_rdata[0] == 1'b0); endproperty
  property p_edge; s_ext_edge |-> s_req_soon; endproperty
  a_gate: assert property (p_gate) else $error("request while global enable off");
  a_t0: assert property (p_t0) else $error("timer0 overflow gave no request");
  a_t1: assert property (p_t1) else $error("timer1 overflow gave no request");
  a_hold: assert property (p_hold) else $error("request dropped without a write");
  a_per: assert property (p_per) else $error("unused peripheral bit read as one");
  a_rst: assert property (p_rst) else $error("reset status upper bits not zero");
  a_bo: assert property (p_bo) else $error("brown-out bit set while disabled");
  a_edge: assert property (p_edge) else $error("chosen pin edge gave no request");
endmodule
`default_nettype wire

// File: bench/interrupt_and_reset_status_tb.sv
// Purpose: bench for the interrupt block and its core end joined by the link
// Assumes: software bus answers within a bounded wait
// Notes:   byte address is register index times four
`timescale 1ns/100ps
`default_nettype none
module interrupt_and_reset_status_tb;
  logic                    mclk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [4:0]              addr = 5'h00;
  logic                    rd = 1'b0;
  logic                    wr = 1'b0;
  logic [31:0]             wdat = 32'h00000000;
  logic [31:0]             rdat;
  logic                    wait_req;
  logic [6:0]              ev = 7'h00;
  logic                    pin = 1'b0;
  logic                    sel = 1'b1;
  logic [5:0]              port = 6'h00;
  logic [1:0]              cmp = 2'h0;
  irq_pkg::capcomp_mode_e  mode = irq_pkg::CC_PWM;
  logic                    irq;
  logic                    bo_en;
  logic [7:0]              q;
  int                      bad_count = 0;
  int                      compares = 0;
  int                      cycles = 0;
  irq_link_if lnk ();
  interrupt_and_reset_status u_interrupt_and_reset_status (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(lnk), .brownout_sw_enable_o(bo_en));
  core_end u_core_end (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(lnk), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req), .timer0_ovf_i(ev[0]),
    .ext_irq_pin_i(pin), .ext_edge_select_i(sel), .io_port_i(port), .comparator_out_i(cmp),
    .converter_done_i(ev[1]), .capture_evt_i(ev[2]), .compare_evt_i(ev[3]), .capcomp_mode_i(mode),
    .timer2_match_i(ev[4]), .timer1_ovf_i(ev[5]), .brownout_evt_i(ev[6]), .irq_o(irq));
  irq_link_chk u_irq_link_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_idx(lnk.reg_idx),
    .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .irq_req(lnk.irq_req),
    .timer0_ovf(lnk.timer0_ovf), .timer1_ovf(lnk.timer1_ovf), .ext_irq_pin(lnk.ext_irq_pin),
    .ext_edge_select(lnk.ext_edge_select));
  // ---------------------------------------------------------------
  // clock, timeout and tasks
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= {idx, 2'b00};
    wr   <= w;
    rd   <= !w;
    wdat <= {24'h000000, d};
    do begin
      @(posedge mclk_i);
    end while (wait_req !== 1'b0);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [2:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [2:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp8(q, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= 7'h00;
    idle(2);
  endtask
  task automatic irqchk(input logic e);
    idle(2);
    cmp8({7'h00, irq}, {7'h00, e});
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rchk(3'(i), 8'h00);
    wreg(irq_pkg::IDX_RSTAT, 8'h03);
    rchk(irq_pkg::IDX_RSTAT, 8'h02);
    wreg(irq_pkg::IDX_RSTAT, 8'hFF);
    rchk(irq_pkg::IDX_RSTAT, 8'h03);
    cmp8({7'h00, bo_en}, 8'h01);
    pulse(7'h40);
    rchk(irq_pkg::IDX_RSTAT, 8'h02);
    pulse(7'h01);
    rchk(irq_pkg::IDX_INTCTL, 8'h04);
    irqchk(1'b0);
    wreg(irq_pkg::IDX_INTCTL, 8'h20);
    rchk(irq_pkg::IDX_INTCTL, 8'h20);
    wreg(irq_pkg::IDX_INTCTL, 8'hA0);
    irqchk(1'b0);
    pulse(7'h01);
    irqchk(1'b1);
    wreg(irq_pkg::IDX_INTCTL, 8'h24);
    irqchk(1'b0);
    wreg(irq_pkg::IDX_INTCTL, 8'h00);
    wreg(irq_pkg::IDX_PIE, 8'hFF);
    rchk(irq_pkg::IDX_PIE, 8'h7B);
    pulse(7'h0C);
    mode <= irq_pkg::CC_CAPTURE;
    pulse(7'h08);
    rchk(irq_pkg::IDX_PIR, 8'h00);
    mode <= irq_pkg::CC_COMPARE;
    pulse(7'h08);
    rchk(irq_pkg::IDX_PIR, 8'h20);
    wreg(irq_pkg::IDX_PIR, 8'h00);
    mode <= irq_pkg::CC_CAPTURE;
    pulse(7'h04);
    rchk(irq_pkg::IDX_PIR, 8'h20);
    pulse(7'h12);
    cmp <= 2'h3;
    idle(6);
    rchk(irq_pkg::IDX_PIR, 8'h7A);
    wreg(irq_pkg::IDX_INTCTL, 8'h80);
    irqchk(1'b0);
    wreg(irq_pkg::IDX_PIR, 8'h00);
    wreg(irq_pkg::IDX_INTCTL, 8'hC0);
    pulse(7'h20);
    rchk(irq_pkg::IDX_PIR, 8'h01);
    irqchk(1'b1);
    wreg(irq_pkg::IDX_PIR, 8'h00);
    irqchk(1'b0);
    wreg(irq_pkg::IDX_INTCTL, 8'h88);
    port <= 6'h01;
    idle(6);
    rchk(irq_pkg::IDX_INTCTL, 8'h89);
    irqchk(1'b0);
    wreg(irq_pkg::IDX_INTCTL, 8'h88);
    wreg(irq_pkg::IDX_PCMASK, 8'h3F);
    port <= 6'h21;
    irqchk(1'b0);
    idle(4);
    irqchk(1'b1);
    wreg(irq_pkg::IDX_INTCTL, 8'h90);
    sel <= 1'b0;
    pin <= 1'b1;
    idle(6);
    rchk(irq_pkg::IDX_INTCTL, 8'h90);
    pin <= 1'b0;
    idle(6);
    rchk(irq_pkg::IDX_INTCTL, 8'h92);
    wreg(irq_pkg::IDX_INTCTL, 8'h90);
    sel <= 1'b1;
    pin <= 1'b1;
    idle(6);
    rchk(irq_pkg::IDX_INTCTL, 8'h92);
    rchk(irq_pkg::IDX_LINKSTAT, 8'h01);
    wreg(3'h7, 8'hFF);
    rchk(3'h7, 8'h00);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rchk(irq_pkg::IDX_RSTAT, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
